// ==== return_and_rotate_carry_exec.sv ====
// Execution unit for subroutine return and rotate-left-through-carry
//
// How it works
// - A return pops the stack and loads the popped top-of-stack value into the program counter.
// - A return with s set copies the three shadow registers into working, status and bank select.
// - A return with s clear leaves working, status and bank select untouched.
// - A return never writes the upper or high program counter latches.
// - The return is the word of eleven zero bits, then 1001, then s in bit 0.
// - The rotate shifts each bit up one place, bit 7 into carry and old carry into bit 0.
// - Rotate destination bit d clear writes working, d set writes back to the file register.
// - Access bit a clear uses the access bank, a set uses the bank select register.
// - The rotate updates carry, negative and zero and leaves the other status flags alone.
// - The rotate is opcode 001101, then d, then a, then an 8-bit file address.
`timescale 1ns/1ns
`default_nettype none
module return_and_rotate_carry_exec #(
  parameter int PC_W = rr_exec_pkg::PC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [PC_W-1:0] topOfStackValue,
  input wire logic [7:0] fileReadData,
  input wire logic [7:0] workingShadow,
  input wire logic [7:0] statusShadow,
  input wire logic [3:0] bankSelectShadow,
  input wire logic [7:0] workingIn,
  input wire logic [7:0] statusIn,
  input wire logic [3:0] bankSelectIn,
  output logic [11:0] fileReadAddr,
  output logic stackPop,
  output logic pcLoad,
  output logic [PC_W-1:0] pcLoadValue,
  output logic flushFetch,
  output logic fileWrite,
  output logic [11:0] fileWriteAddr,
  output logic [7:0] fileWriteData,
  output logic workingWrite,
  output logic [7:0] workingOut,
  output logic statusWrite,
  output logic [7:0] statusOut,
  output logic bankSelectWrite,
  output logic [3:0] bankSelectOut,
  output logic busy
);
  typedef enum logic {ExecIdle, ExecRetNop} exec_state_t;

  rr_exec_if fields ();

  rr_decode u_decode (
    .instrWord(instrWord),
    .fields(fields)
  );

  // Effective file address: bank from a bit, used by both read and write
  function automatic logic [11:0] fileAddress(input logic useBank, input logic [3:0] bank_select_register, input logic [7:0] addr);
    logic [3:0] bank;
    bank = (addr < rr_exec_pkg::ACCESS_SPLIT) ? rr_exec_pkg::ACCESS_LOW_BANK : rr_exec_pkg::ACCESS_HIGH_BANK;
    if (useBank) begin
      bank = bank_select_register;
    end
    return {bank, addr};
  endfunction

  exec_state_t state_r;
  exec_state_t state_nxt;
  logic stackPop_r;
  logic pcLoad_r;
  logic [PC_W-1:0] pcLoadValue_r;
  logic flushFetch_r;
  logic fileWrite_r;
  logic [11:0] fileWriteAddr_r;
  logic [7:0] fileWriteData_r;
  logic workingWrite_r;
  logic [7:0] workingOut_r;
  logic statusWrite_r;
  logic [7:0] statusOut_r;
  logic bankSelectWrite_r;
  logic [3:0] bankSelectOut_r;
  logic busy_r;
  logic [7:0] statusMix;

  wire logic [7:0] rotResult;
  wire logic rotCarry;
  wire logic rotNeg;
  wire logic rotZero;
  wire logic doReturn;
  wire logic doRotate;
  wire logic doRestore;
  wire logic [11:0] effAddr;
  wire logic [7:0] rotStatus;

  // An instruction arriving in the refill cycle is the stale fetch and is dropped
  assign doReturn = instrValid && state_r == ExecIdle && fields.isReturn;
  assign doRotate = instrValid && state_r == ExecIdle && fields.isRotate;
  assign doRestore = doReturn && fields.restoreShadow;
  assign effAddr = fileAddress(fields.useBank, bankSelectIn, fields.fileAddr);

  rr_rotate u_rotate (
    .srcData(fileReadData),
    .carryIn(statusIn[rr_exec_pkg::ST_C]),
    .result(rotResult),
    .carryOut(rotCarry),
    .negFlag(rotNeg),
    .zeroFlag(rotZero)
  );

  // Only C, N and Z are replaced; the remaining status bits pass through
  always_comb begin
    statusMix = statusIn;
    statusMix[rr_exec_pkg::ST_C] = rotCarry;
    statusMix[rr_exec_pkg::ST_N] = rotNeg;
    statusMix[rr_exec_pkg::ST_Z] = rotZero;
  end
  assign rotStatus = statusMix;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ExecIdle: begin
        if (doReturn) begin
          state_nxt = ExecRetNop;
        end
      end
      ExecRetNop: begin
        state_nxt = ExecIdle;
      end
    endcase
  end

  // Combinational read address so the file data is ready within the same instruction cycle
  assign fileReadAddr = effAddr;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ExecIdle;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= state_nxt == ExecRetNop;
    end
  end

  // Return side effects; the pc latches have no port here at all
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stackPop_r <= 1'b0;
      pcLoad_r <= 1'b0;
      pcLoadValue_r <= '0;
      flushFetch_r <= 1'b0;
    end else begin
      stackPop_r <= doReturn;
      pcLoad_r <= doReturn;
      flushFetch_r <= doReturn;
      if (doReturn) begin
        pcLoadValue_r <= topOfStackValue;
      end
    end
  end

  // Rotate writes the destination chosen by d; return may restore shadows
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fileWrite_r <= 1'b0;
      fileWriteAddr_r <= 12'h000;
      fileWriteData_r <= 8'h00;
      workingWrite_r <= 1'b0;
      workingOut_r <= 8'h00;
      statusWrite_r <= 1'b0;
      statusOut_r <= 8'h00;
      bankSelectWrite_r <= 1'b0;
      bankSelectOut_r <= 4'h0;
    end else begin
      fileWrite_r <= doRotate && fields.toFile;
      workingWrite_r <= (doRotate && !fields.toFile) || doRestore;
      statusWrite_r <= doRotate || doRestore;
      bankSelectWrite_r <= doRestore;
      if (doRotate) begin
        fileWriteAddr_r <= effAddr;
        fileWriteData_r <= rotResult;
        workingOut_r <= rotResult;
        statusOut_r <= rotStatus;
      end else if (doRestore) begin
        workingOut_r <= workingShadow;
        statusOut_r <= statusShadow;
        bankSelectOut_r <= bankSelectShadow;
      end
    end
  end

  assign stackPop = stackPop_r;
  assign pcLoad = pcLoad_r;
  assign pcLoadValue = pcLoadValue_r;
  assign flushFetch = flushFetch_r;
  assign fileWrite = fileWrite_r;
  assign fileWriteAddr = fileWriteAddr_r;
  assign fileWriteData = fileWriteData_r;
  assign workingWrite = workingWrite_r;
  assign workingOut = workingOut_r;
  assign statusWrite = statusWrite_r;
  assign statusOut = statusOut_r;
  assign bankSelectWrite = bankSelectWrite_r;
  assign bankSelectOut = bankSelectOut_r;
  assign busy = busy_r;
endmodule
`default_nettype wire

// ==== rr_decode.sv ====
// Instruction word decoder for return and rotate-through-carry
`timescale 1ns/1ns
`default_nettype none
module rr_decode (
  input wire logic [15:0] instrWord,
  rr_exec_if.dec fields
);
  wire logic retMatch;
  wire logic rlcMatch;
  assign retMatch = instrWord[15:1] == rr_exec_pkg::RET_PATTERN;
  assign rlcMatch = instrWord[rr_exec_pkg::OPC_MSB:rr_exec_pkg::OPC_LSB] == rr_exec_pkg::RLC_OPCODE;
  assign fields.isReturn = retMatch;
  assign fields.restoreShadow = instrWord[rr_exec_pkg::RET_S_BIT];
  assign fields.isRotate = rlcMatch;
  assign fields.toFile = instrWord[rr_exec_pkg::RLC_D_BIT];
  assign fields.useBank = instrWord[rr_exec_pkg::RLC_A_BIT];
  assign fields.fileAddr = instrWord[7:0];
endmodule
`default_nettype wire

// ==== rr_exec_if.sv ====
// Decoded instruction fields passed from the decoder to the executer
`timescale 1ns/1ns
`default_nettype none
interface rr_exec_if;
  logic isReturn;
  logic restoreShadow;
  logic isRotate;
  logic toFile;
  logic useBank;
  logic [7:0] fileAddr;
  modport dec (output isReturn, output restoreShadow, output isRotate, output toFile, output useBank,
    output fileAddr);
  modport exe (input isReturn, input restoreShadow, input isRotate, input toFile, input useBank,
    input fileAddr);
endinterface
`default_nettype wire

// ==== rr_exec_pkg.sv ====
// Shared constants for the return and rotate-through-carry execution block
package rr_exec_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int PC_W = 21;
  // Subroutine return: upper fifteen bits fixed, bit 0 is the shadow-restore flag
  localparam logic [14:0] RET_PATTERN = 15'h0009;
  localparam int RET_S_BIT = 0;
  // Rotate left through carry: opcode in bits 15:10
  localparam logic [5:0] RLC_OPCODE = 6'h0D;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 10;
  localparam int RLC_D_BIT = 9;
  localparam int RLC_A_BIT = 8;
  // Status flag positions
  localparam int ST_C = 0;
  localparam int ST_Z = 2;
  localparam int ST_N = 4;
  // Access bank: addresses below the split map to bank 0, the rest to the top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [20:0] PC_RESET = 21'h00_0000;
endpackage

// ==== rr_exec_properties.sv ====
// Port-level checks for the execution unit
`timescale 1ns/1ns
`default_nettype none
module rr_exec_properties #(
  parameter int PC_W = rr_exec_pkg::PC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [PC_W-1:0] topOfStackValue,
  input wire logic [7:0] fileReadData,
  input wire logic [7:0] workingShadow,
  input wire logic [7:0] statusIn,
  input wire logic [3:0] bankSelectIn,
  input wire logic [11:0] fileReadAddr,
  input wire logic stackPop,
  input wire logic pcLoad,
  input wire logic [PC_W-1:0] pcLoadValue,
  input wire logic flushFetch,
  input wire logic fileWrite,
  input wire logic [7:0] fileWriteData,
  input wire logic workingWrite,
  input wire logic [7:0] workingOut,
  input wire logic statusWrite,
  input wire logic [7:0] statusOut,
  input wire logic bankSelectWrite,
  input wire logic busy
);
  wire logic isRet = instrValid && !busy && instrWord[15:1] == 15'h0009;
  wire logic isRlc = instrValid && !busy && instrWord[15:10] == 6'h0D;
  wire logic [7:0] rlcRes = {fileReadData[6:0], statusIn[0]};
  wire logic [7:0] stExp = {statusIn[7:5], rlcRes[7], statusIn[3], rlcRes == 8'h00, statusIn[1], fileReadData[7]};
  wire logic [3:0] bankExp = instrWord[8] ? bankSelectIn : {4{instrWord[7]}};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence retFirst;
    stackPop && pcLoad && flushFetch && busy;
  endsequence
  sequence retSecond;
    !busy && !pcLoad && !stackPop;
  endsequence
  AST_RET_STEPS: assert property (isRet |=> retFirst ##1 retSecond)
    else $error("return sequence wrong");
  AST_RET_PC: assert property (isRet |=> pcLoadValue == $past(topOfStackValue))
    else $error("pc not loaded from stack");
  AST_RET_SHADOW: assert property (isRet && instrWord[0] |=> workingWrite && statusWrite && bankSelectWrite
    && workingOut == $past(workingShadow)) else $error("shadow restore missing");
  AST_RET_KEEP: assert property (isRet && !instrWord[0] |=> !(workingWrite || statusWrite || bankSelectWrite))
    else $error("registers touched without restore");
  AST_IGNORE: assert property (!(isRet || isRlc) |=> !(stackPop || fileWrite || workingWrite || statusWrite))
    else $error("foreign word acted on");
  AST_RLC_ADDR: assert property (isRlc |-> fileReadAddr == {bankExp, instrWord[7:0]})
    else $error("rotate address wrong");
  AST_RLC_FILE: assert property (isRlc && instrWord[9] |=> fileWrite && !workingWrite
    && fileWriteData == $past(rlcRes)) else $error("rotate file result wrong");
  AST_RLC_W: assert property (isRlc && !instrWord[9] |=> workingWrite && !fileWrite
    && workingOut == $past(rlcRes)) else $error("rotate working result wrong");
  AST_RLC_FLAGS: assert property (isRlc |=> statusWrite && statusOut == $past(stExp))
    else $error("rotate flags wrong");
endmodule
bind return_and_rotate_carry_exec rr_exec_properties #(.PC_W(PC_W)) i_rr_exec_properties (.clk_sys, .rst_n,
  .instrValid, .instrWord, .topOfStackValue, .fileReadData, .workingShadow, .statusIn, .bankSelectIn, .fileReadAddr,
  .stackPop, .pcLoad, .pcLoadValue, .flushFetch, .fileWrite, .fileWriteData, .workingWrite, .workingOut,
  .statusWrite, .statusOut, .bankSelectWrite, .busy);
`default_nettype wire

// ==== rr_mem_model.sv ====
// Data memory and return stack facing the execution unit
`timescale 1ns/1ns
`default_nettype none
module rr_mem_model (
  input wire logic clk_sys,
  input wire logic [11:0] fileReadAddr,
  input wire logic fileWrite,
  input wire logic [11:0] fileWriteAddr,
  input wire logic [7:0] fileWriteData,
  input wire logic stackPop,
  output logic [7:0] fileReadData,
  output logic [20:0] topOfStackValue
);
  logic [7:0] mem [4096];
  logic [20:0] stk [4];
  logic [1:0] sp = 2'd3;
  initial for (int i = 0; i < 4; i++) stk[i] = {5'(i + 3), 16'hA5C3};
  assign fileReadData = mem[fileReadAddr];
  assign topOfStackValue = stk[sp];
  // Stack wraps silently: underflow is not modelled
  always @(posedge clk_sys) begin
    if (fileWrite) mem[fileWriteAddr] <= fileWriteData;
    if (stackPop) sp <= sp - 2'd1;
  end
endmodule
`default_nettype wire

// ==== rr_rotate.sv ====
// Rotate-left-through-carry datapath with flag results
`timescale 1ns/1ns
`default_nettype none
module rr_rotate (
  input wire logic [7:0] srcData,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic carryOut,
  output logic negFlag,
  output logic zeroFlag
);
  assign result = {srcData[6:0], carryIn};
  assign carryOut = srcData[7];
  assign negFlag = result[7];
  assign zeroFlag = result == rr_exec_pkg::ZERO_BYTE;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the return and rotate execution unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, rst_n = 1'b0, instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [7:0] workingShadow = 8'h3C, statusShadow = 8'h15, workingIn = 8'h00, statusIn = 8'h00;
  logic [3:0] bankSelectShadow = 4'h9, bankSelectIn = 4'h2, bankSelectOut;
  logic [20:0] topOfStackValue, pcLoadValue;
  logic [7:0] fileReadData, workingOut, statusOut, fileWriteData;
  logic [11:0] fileReadAddr, fileWriteAddr;
  logic stackPop, pcLoad, flushFetch, fileWrite, workingWrite, statusWrite, bankSelectWrite, busy;
  int n_errors = 0;
  int num_checks = 0;
  return_and_rotate_carry_exec i_return_and_rotate_carry_exec (.clk_sys, .rst_n, .instrValid, .instrWord,
    .topOfStackValue, .fileReadData, .workingShadow, .statusShadow, .bankSelectShadow, .workingIn, .statusIn,
    .bankSelectIn, .fileReadAddr, .stackPop, .pcLoad, .pcLoadValue, .flushFetch, .fileWrite, .fileWriteAddr,
    .fileWriteData, .workingWrite, .workingOut, .statusWrite, .statusOut, .bankSelectWrite, .bankSelectOut, .busy);
  rr_mem_model i_rr_mem_model (.clk_sys, .fileReadAddr, .fileWrite, .fileWriteAddr, .fileWriteData, .stackPop,
    .fileReadData, .topOfStackValue);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_return(input logic s);
    logic [20:0] top_of_stack_value;
    top_of_stack_value = topOfStackValue;
    instrValid = 1'b1;
    instrWord = {15'h0009, s};
    @(posedge clk_sys);
    #1 chk(stackPop && pcLoad && flushFetch && pcLoadValue === top_of_stack_value, "pop to pc");
    chk(workingWrite === s && statusWrite === s && bankSelectWrite === s, "shadow writes");
    chk(!s || {workingOut, statusOut, bankSelectOut} === {workingShadow, statusShadow, bankSelectShadow},
      "copy");
    chk(busy === 1'b1, "busy");
    // Fetched behind the return, so it must be dropped
    instrWord = 16'h3601;
    @(posedge clk_sys);
    #1 chk(!fileWrite && !stackPop && !busy, "stale word acted on");
  endtask
  task automatic t_rotate(input logic d, a, input logic [7:0] f, src, st);
    logic [7:0] res;
    logic [11:0] adr;
    res = {src[6:0], st[0]};
    adr = {a ? bankSelectIn : {4{f[7]}}, f};
    i_rr_mem_model.mem[adr] = src;
    statusIn = st;
    instrValid = 1'b1;
    instrWord = {6'h0D, d, a, f};
    #1 chk(fileReadAddr === adr, "read address");
    @(posedge clk_sys);
    #1 chk(fileWrite === d && workingWrite === !d && (!d || fileWriteAddr === adr), "destination");
    chk((d ? fileWriteData : workingOut) === res, "rotated value");
    chk(statusWrite && statusOut === {st[7:5], res[7], st[3], res == 8'h00, st[1], src[7]}, "flags");
  endtask
  // Mid-run reset with a return pending; the first word after release must be taken
  task automatic t_reset;
    logic [20:0] top_of_stack_value;
    top_of_stack_value = topOfStackValue;
    rst_n = 1'b0;
    instrValid = 1'b1;
    instrWord = 16'h0013;
    repeat (2) @(posedge clk_sys);
    #1 chk(!(stackPop | pcLoad | flushFetch | busy), "reset pulses");
    chk(!(fileWrite | workingWrite | statusWrite | bankSelectWrite), "reset writes");
    chk({pcLoadValue, workingOut, statusOut, bankSelectOut} === '0, "reset data");
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1 chk(stackPop && busy && pcLoadValue === top_of_stack_value, "return after reset");
  endtask
  task automatic t_other(input logic v, input logic [15:0] w);
    instrValid = v;
    instrWord = w;
    @(posedge clk_sys);
    #1 chk(!(fileWrite | workingWrite | statusWrite | stackPop), "foreign word acted on");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_return(1'b1);
    t_return(1'b0);
    for (int i = 0; i < 4; i++) t_rotate(i[0], i[1], 8'(8'h7F + i), 8'(8'hB3 ^ (i * 64)), 8'(8'hAA + i));
    t_rotate(1'b1, 1'b0, 8'hFF, 8'h80, 8'h54);
    t_reset();
    t_other(1'b1, 16'h0014);
    t_other(1'b1, 16'h3800);
    t_other(1'b0, 16'h3610);
    end_sim();
  end
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
